// ---- hdl/vte_engine.sv ----
// Purpose: reverse and forward coordinate transformation engine
// Assumes: host registers arrive as plain ports with write strobes
// Notes:   one transform at a time; completion at a fixed cycle count
`timescale 1ns/1ps
`default_nettype none
module vte_engine
(
    input  wire logic                    core_clk,
    input  wire logic                    resetn,
    input  wire logic [11:0]             system_control,
    input  wire vte_pkg::vte_three_s     phase_current_in,
    input  wire logic signed [11:0]      direct_voltage_in,
    input  wire logic signed [11:0]      quadrature_voltage_in,
    input  wire logic [11:0]             angle_wdata,
    input  wire logic                    reverse_angle_wr,
    input  wire logic                    forward_angle_wr,
    input  wire logic                    status_rd,
    output logic [11:0]                  system_status,
    output vte_pkg::vte_pair_s           stator_current,
    output vte_pkg::vte_pair_s           rotor_current,
    output vte_pkg::vte_pair_s           stator_voltage,
    output vte_pkg::vte_three_s          phase_voltage_out,
    output logic                         busy,
    output logic                         done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vte_pkg::vte_state_e       state_ff;
    vte_pkg::vte_state_e       nxt_state;
    logic [5:0]                cnt_ff;
    logic [11:0]               angle_ff;
    logic                      vt_flag_ff;
    logic                      sum_flag_ff;
    vte_pkg::vte_pair_s        ixy_ff;
    vte_pkg::vte_pair_s        dq_ff;
    vte_pkg::vte_pair_s        vxy_ff;
    vte_pkg::vte_three_s       pv_ff;

    // ------------------------------------------------------------
    // start and completion decode
    // ------------------------------------------------------------
    wire logic idle      = (state_ff == vte_pkg::VTE_IDLE);
    wire logic start_rev = idle && reverse_angle_wr;
    wire logic start_fwd = idle && forward_angle_wr && !reverse_angle_wr;
    wire logic fin_rev   = (state_ff == vte_pkg::VTE_REV)
                           && (cnt_ff == vte_pkg::REV_CYCLES - 6'h01);
    wire logic fin_fwd   = (state_ff == vte_pkg::VTE_FWD)
                           && (cnt_ff == vte_pkg::FWD_CYCLES - 6'h01);
    wire logic finish    = fin_rev || fin_fwd;
    wire logic three_mode = system_control[vte_pkg::CTRL_THREE];
    wire logic irq_en     = system_control[vte_pkg::CTRL_IRQ_EN];

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            vte_pkg::VTE_IDLE:
            begin
                if (start_rev)
                    nxt_state = vte_pkg::VTE_REV;
                else if (start_fwd)
                    nxt_state = vte_pkg::VTE_FWD;
            end
            vte_pkg::VTE_REV:
            begin
                if (fin_rev)
                    nxt_state = vte_pkg::VTE_IDLE;
            end
            vte_pkg::VTE_FWD:
            begin
                if (fin_fwd)
                    nxt_state = vte_pkg::VTE_IDLE;
            end
            default:
            begin
                nxt_state = vte_pkg::VTE_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sine and cosine of latched angle
    // ------------------------------------------------------------
    logic signed [15:0] sin_q;
    logic signed [15:0] cos_q;

    vte_sincos u_sincos
    (
        .angle (angle_ff),
        .sin_q (sin_q),
        .cos_q (cos_q)
    );

    // ------------------------------------------------------------
    // reverse datapath
    // ------------------------------------------------------------
    // signed operands
    wire logic signed [13:0] ph1 = 14'(phase_current_in.p1);
    wire logic signed [13:0] ph2 = 14'(phase_current_in.p2);
    wire logic signed [13:0] ph3 = 14'(phase_current_in.p3);
    wire logic signed [13:0] x_src = three_mode ? ph1 : (-ph2 - ph3);
    wire logic signed [13:0] y_dif = ph3 - ph2;
    logic signed [11:0] ix_sat;
    logic signed [11:0] iy_sat;
    logic signed [11:0] id_sat;
    logic signed [11:0] iq_sat;

    vte_sat u_sat_ix
    (
        .wide   (32'(x_src) <<< vte_pkg::KSH),
        .narrow (ix_sat)
    );

    vte_sat u_sat_iy
    (
        .wide   (32'(y_dif) * 32'(vte_pkg::K_INV_SQRT3)),
        .narrow (iy_sat)
    );

    wire logic signed [31:0] id_w = 32'(ixy_ff.a) * 32'(cos_q) + 32'(ixy_ff.b) * 32'(sin_q);
    wire logic signed [31:0] iq_w = 32'(ixy_ff.b) * 32'(cos_q) - 32'(ixy_ff.a) * 32'(sin_q);

    vte_sat u_sat_id
    (
        .wide   (id_w),
        .narrow (id_sat)
    );

    vte_sat u_sat_iq
    (
        .wide   (iq_w),
        .narrow (iq_sat)
    );

    // ------------------------------------------------------------
    // forward datapath
    // ------------------------------------------------------------
    // forward rotation
    wire logic signed [31:0] vx_w = 32'(dq_ff.a) * 32'(cos_q) - 32'(dq_ff.b) * 32'(sin_q);
    wire logic signed [31:0] vy_w = 32'(dq_ff.a) * 32'(sin_q) + 32'(dq_ff.b) * 32'(cos_q);
    logic signed [11:0] vx_sat;
    logic signed [11:0] vy_sat;

    vte_sat u_sat_vx
    (
        .wide   (vx_w),
        .narrow (vx_sat)
    );

    vte_sat u_sat_vy
    (
        .wide   (vy_w),
        .narrow (vy_sat)
    );

    wire logic signed [31:0] half_x = 32'(vxy_ff.a) <<< (vte_pkg::KSH - 1);
    wire logic signed [31:0] ry     = 32'(vxy_ff.b) * 32'(vte_pkg::K_SQRT3_2);
    logic signed [11:0] pv2_sat;
    logic signed [11:0] pv3_sat;

    vte_sat u_sat_pv2
    (
        .wide   (-half_x - ry),
        .narrow (pv2_sat)
    );

    vte_sat u_sat_pv3
    (
        .wide   (-half_x + ry),
        .narrow (pv3_sat)
    );

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // state, counter and angle latch on either start
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_ff <= vte_pkg::VTE_IDLE;
            cnt_ff   <= 6'h00;
            angle_ff <= 12'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= (start_rev || start_fwd || finish) ? 6'h00 : cnt_ff + 6'h01;
            if (start_rev || start_fwd)
                angle_ff <= angle_wdata;
        end
    end

    // ------------------------------------------------------------
    // pipeline stages inside the run
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ixy_ff <= '0;
            dq_ff  <= '0;
            vxy_ff <= '0;
            pv_ff  <= '0;
        end
        else
        begin
            if (start_rev)
                ixy_ff <= '{a: ix_sat, b: iy_sat};
            if (start_fwd)
                dq_ff  <= '{a: direct_voltage_in, b: quadrature_voltage_in};
            if (state_ff == vte_pkg::VTE_FWD && cnt_ff == 6'h01)
                vxy_ff <= '{a: vx_sat, b: vy_sat};
            if (state_ff == vte_pkg::VTE_FWD && cnt_ff == 6'h02)
                pv_ff  <= '{p1: vxy_ff.a, p2: pv2_sat, p3: pv3_sat};
        end
    end

    // ------------------------------------------------------------
    // result registers, published at completion
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            stator_current    <= '0;
            rotor_current     <= '0;
            stator_voltage    <= '0;
            phase_voltage_out <= '0;
        end
        else if (fin_rev)
        begin
            stator_current <= ixy_ff;
            rotor_current  <= '{a: id_sat, b: iq_sat};
        end
        else if (fin_fwd)
        begin
            stator_voltage    <= vxy_ff;
            phase_voltage_out <= pv_ff;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // source flag
    wire logic irq_evt = finish && irq_en;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            vt_flag_ff  <= 1'b0;
            sum_flag_ff <= 1'b0;
            done        <= 1'b0;
        end
        else
        begin
            vt_flag_ff  <= irq_evt || (vt_flag_ff && !status_rd);
            sum_flag_ff <= irq_evt || (sum_flag_ff && !status_rd);
            done        <= finish;
        end
    end

    always_comb
    begin
        system_status = vte_pkg::STAT_RESET;
        system_status[vte_pkg::STAT_VT_BIT]  = vt_flag_ff;
        system_status[vte_pkg::STAT_SUM_BIT] = sum_flag_ff;
    end

    assign busy = !idle;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence rev_run;
        (state_ff == vte_pkg::VTE_REV) [*8];
    endsequence

    AST_REV_DONE_37: assert property (@(posedge core_clk) disable iff (!resetn)
        start_rev |-> ##37 fin_rev ##1 done)
        else $error("reverse done not at 37");

    AST_FWD_DONE_40: assert property (@(posedge core_clk) disable iff (!resetn)
        start_fwd |-> ##40 fin_fwd ##1 done)
        else $error("forward done not at 40");

    AST_REV_NO_EARLY: assert property (@(posedge core_clk) disable iff (!resetn)
        start_rev |=> rev_run ##0 !done)
        else $error("reverse run broken early");

    AST_NO_START_BUSY: assert property (@(posedge core_clk) disable iff (!resetn)
        busy && !finish |=> $stable(angle_ff))
        else $error("angle changed while busy");

    AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!resetn)
        finish && irq_en |=> system_status[1] && system_status[11])
        else $error("flags not set on done");

    AST_NO_IRQ_DIS: assert property (@(posedge core_clk) disable iff (!resetn)
        !system_status[11] && !(finish && irq_en) |=> !system_status[11])
        else $error("flag set without enable");

    AST_READ_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
        status_rd && !irq_evt |=> system_status == 12'h000)
        else $error("status not cleared by read");

    AST_MODE_DERIVE: assert property (@(posedge core_clk) disable iff (!resetn)
        start_rev && !three_mode && (ph2 + ph3 < 14'sh0800) && (ph2 + ph3 > -14'sh0800)
        |=> 14'(ixy_ff.a) == -($past(ph2) + $past(ph3)))
        else $error("derived phase wrong");

    AST_PV1_X: assert property (@(posedge core_clk) disable iff (!resetn)
        fin_fwd |=> phase_voltage_out.p1 == stator_voltage.a)
        else $error("phase one not x");

    AST_SAT_POS: assert property (@(posedge core_clk) disable iff (!resetn)
        start_rev && !three_mode && (ph2 + ph3 < -14'sh07ff) |=> ixy_ff.a == 12'sh7ff)
        else $error("derived x not clamped");

endmodule : vte_engine
`default_nettype wire

// ---- hdl/vte_pkg.sv ----
// Purpose: shared constants and carriers for the vector transform engine
// Assumes: 12-bit twos complement data, 12-bit angle, 100 MHz core clock
// Notes:   bit positions of control/status words held here
package vte_pkg;

    // ------------------------------------------------------------
    // widths and bit positions
    // ------------------------------------------------------------
    localparam int unsigned DW            = 12;
    localparam int unsigned AW            = 12;
    localparam int unsigned CTRL_IRQ_EN   = 6;
    localparam int unsigned CTRL_THREE    = 10;
    localparam int unsigned STAT_VT_BIT   = 1;
    localparam int unsigned STAT_SUM_BIT  = 11;
    localparam logic [11:0] CTRL_RESET    = 12'h000;
    localparam logic [11:0] STAT_RESET    = 12'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [5:0]  REV_CYCLES    = 6'h25;
    localparam logic [5:0]  FWD_CYCLES    = 6'h28;

    // ------------------------------------------------------------
    // fixed-point constants, q1.14
    // ------------------------------------------------------------
    localparam logic signed [15:0] K_INV_SQRT3 = 16'sh24f3;
    localparam logic signed [15:0] K_SQRT3_2   = 16'sh376d;
    localparam int unsigned        KSH         = 14;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [11:0] p1;
        logic signed [11:0] p2;
        logic signed [11:0] p3;
    } vte_three_s;

    typedef struct packed {
        logic signed [11:0] a;
        logic signed [11:0] b;
    } vte_pair_s;

    typedef enum logic [1:0] {
        VTE_IDLE = 2'b00,
        VTE_REV  = 2'b01,
        VTE_FWD  = 2'b10
    } vte_state_e;

endpackage : vte_pkg

// ---- hdl/vte_sincos.sv ----
// Purpose: sine and cosine of an unsigned 12-bit turn fraction
// Assumes: combinational, q1.14 outputs
// Notes:   quarter-wave table of 17 points, linear interpolation
`timescale 1ns/1ps
`default_nettype none
module vte_sincos
(
    input  wire logic [11:0]        angle,
    output logic signed [15:0]      sin_q,
    output logic signed [15:0]      cos_q
);

    // ------------------------------------------------------------
    // quarter table
    // ------------------------------------------------------------
    function automatic logic [15:0] qsin(input logic [10:0] ph);
        logic [15:0] tab [0:16];
        logic [4:0]  i;
        logic [6:0]  f;
        logic [23:0] d;
        tab[0]  = 16'h0000; tab[1]  = 16'h0648; tab[2]  = 16'h0c7c;
        tab[3]  = 16'h1294; tab[4]  = 16'h187e; tab[5]  = 16'h1e2b;
        tab[6]  = 16'h238e; tab[7]  = 16'h2899; tab[8]  = 16'h2d41;
        tab[9]  = 16'h317a; tab[10] = 16'h3537; tab[11] = 16'h3871;
        tab[12] = 16'h3b21; tab[13] = 16'h3d3f; tab[14] = 16'h3ec5;
        tab[15] = 16'h3fb1; tab[16] = 16'h4000;
        i = ph[10:6];
        f = {1'b0, ph[5:0]};
        if (i == 5'h10)
        begin
            qsin = tab[16];
        end
        else
        begin
            d = {8'h00, tab[i + 5'h01] - tab[i]} * {17'h00000, f};
            qsin = tab[i] + d[21:6];
        end
    endfunction : qsin

    // ------------------------------------------------------------
    // quadrant folding
    // ------------------------------------------------------------
    function automatic logic signed [15:0] wave(input logic [11:0] a);
        logic [10:0] ph;
        ph = a[10] ? (11'h400 - {1'b0, a[9:0]}) : {1'b0, a[9:0]};
        wave = a[11] ? -$signed(qsin(ph)) : $signed(qsin(ph));
    endfunction : wave

    wire logic [11:0] cos_angle = angle + 12'h400;

    assign sin_q = wave(angle);
    assign cos_q = wave(cos_angle);

endmodule : vte_sincos
`default_nettype wire

// ---- hdl/vte_sat.sv ----
// Purpose: scale a wide product sum and clamp it to 12 bits
// Assumes: input in q.14 units of the 12-bit data
// Notes:   rounds half up before clamping
`timescale 1ns/1ps
`default_nettype none
module vte_sat
(
    input  wire logic signed [31:0] wide,
    output logic signed [11:0]      narrow
);

    wire logic signed [31:0] rnd    = wide + 32'sh00002000;
    wire logic signed [31:0] scaled = rnd >>> vte_pkg::KSH;

    assign narrow = (scaled > 32'sh000007ff) ? 12'sh7ff :
                    (scaled < -32'sh00000800) ? 12'sh800 : scaled[11:0];

endmodule : vte_sat
`default_nettype wire

// ---- tb/vte_host_model.sv ----
// Purpose: host model driving the transform engine register ports
// Assumes: every change lands on the falling clock edge
// Notes:   angle bus shows the inverse of its last value between writes
`timescale 1ns/1ps
`default_nettype none
module vte_host_model
(
    input  wire logic           core_clk,
    input  wire logic           busy,
    output vte_pkg::vte_three_s phase_current_in,
    output logic [11:0]         system_control,
    output logic signed [11:0]  direct_voltage_in,
    output logic signed [11:0]  quadrature_voltage_in,
    output logic [11:0]         angle_wdata,
    output logic                reverse_angle_wr,
    output logic                forward_angle_wr,
    output logic                status_rd
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial
    begin
        phase_current_in      = '0;
        system_control        = 12'h000;
        direct_voltage_in     = 12'sh000;
        quadrature_voltage_in = 12'sh000;
        angle_wdata           = 12'h000;
        reverse_angle_wr      = 1'b0;
        forward_angle_wr      = 1'b0;
        status_rd             = 1'b0;
    end

    // ------------------------------------------------------------
    // data, then angle; rude skips the wait and the data
    // ------------------------------------------------------------
    task automatic start(input bit fwd, input bit rude, input logic [11:0] ctrl, input logic [11:0] a,
                         input logic [11:0] b, input logic [11:0] c, input logic [11:0] ang);
        int n;
        n = 0;
        if (!rude)
        begin
            while (busy !== 1'b0 && n < 100)
            begin
                @(negedge core_clk);
                n++;
            end
            system_control = ctrl;
            if (fwd)
            begin
                direct_voltage_in     = a;
                quadrature_voltage_in = b;
            end
            else
            begin
                if (ctrl[vte_pkg::CTRL_THREE])
                    phase_current_in.p1 = a;
                phase_current_in.p2 = b;
                phase_current_in.p3 = c;
            end
            @(negedge core_clk);
        end
        angle_wdata = ang;
        if (fwd)
            forward_angle_wr = 1'b1;
        else
            reverse_angle_wr = 1'b1;
        @(negedge core_clk);
        forward_angle_wr = 1'b0;
        reverse_angle_wr = 1'b0;
        angle_wdata      = ~ang;
    endtask : start

    task automatic read_status();
        status_rd = 1'b1;
        @(negedge core_clk);
        status_rd = 1'b0;
    endtask : read_status
endmodule : vte_host_model
`default_nettype wire

// ---- tb/vector_transform_engine_tb_top.sv ----
// Purpose: self-checking bench for the transform engine
// Assumes: reference model in reals, results rounded and clamped to 12 bits
// Notes:   tolerance covers the engine's interpolated sine table
`timescale 1ns/1ps
`default_nettype none
module vector_transform_engine_tb_top;
    logic                core_clk;
    logic                resetn;
    logic [11:0]         system_control;
    vte_pkg::vte_three_s phase_current_in;
    logic signed [11:0]  direct_voltage_in;
    logic signed [11:0]  quadrature_voltage_in;
    logic [11:0]         angle_wdata;
    logic                reverse_angle_wr;
    logic                forward_angle_wr;
    logic                status_rd;
    logic [11:0]         system_status;
    vte_pkg::vte_pair_s  stator_current;
    vte_pkg::vte_pair_s  rotor_current;
    vte_pkg::vte_pair_s  stator_voltage;
    vte_pkg::vte_three_s phase_voltage_out;
    logic                busy;
    logic                done;
    int                  failures;
    int                  total_checks;
    int                  exp_q[$];
    logic [11:0]         angs[6] = '{12'h000, 12'h200, 12'h400, 12'h800, 12'hc00, 12'hfff};

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    vte_host_model host_u (.core_clk, .busy, .phase_current_in, .system_control, .direct_voltage_in,
        .quadrature_voltage_in, .angle_wdata, .reverse_angle_wr, .forward_angle_wr, .status_rd);
    vte_engine dut_u (.core_clk, .resetn, .system_control, .phase_current_in, .direct_voltage_in,
        .quadrature_voltage_in, .angle_wdata, .reverse_angle_wr, .forward_angle_wr, .status_rd,
        .system_status, .stator_current, .rotor_current, .stator_voltage, .phase_voltage_out, .busy, .done);

    // ------------------------------------------------------------
    // compare and verdict
    // ------------------------------------------------------------
    task automatic close_out();
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk_bits(input logic [11:0] got, input logic [11:0] expv);
        total_checks++;
        if (got !== expv)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expv);
        end
    endtask : chk_bits

    task automatic chk_val(input logic [11:0] got, input int expv, input int tol);
        int d;
        d = int'($signed(got)) - expv;
        total_checks++;
        if ((^got) === 1'bx || d > tol || d < -tol)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, 12'(expv));
        end
    endtask : chk_val

    function automatic int sat(input real v);
        int r;
        r = int'(v);
        return (r > 2047) ? 2047 : ((r < -2048) ? -2048 : r);
    endfunction : sat

    function automatic int rnd();
        return int'($urandom_range(2400)) - 1200;
    endfunction : rnd

    // ------------------------------------------------------------
    // one transform: model, start, timing, results, flags
    // ------------------------------------------------------------
    task automatic run(input bit fwd, input logic [11:0] ctrl, input int a, input int b, input int c,
                       input logic [11:0] ang, input bit poke);
        real th, s, co, x, y;
        int  n, extra;
        th = 6.283185307179586 * real'(ang) / 4096.0;
        s  = $sin(th);
        co = $cos(th);
        if (fwd)
        begin
            x     = sat(real'(a) * co - real'(b) * s);
            y     = sat(real'(a) * s + real'(b) * co);
            exp_q = {int'(x), int'(y), sat(-x / 2.0 - 0.8660254 * y), sat(-x / 2.0 + 0.8660254 * y)};
        end
        else
        begin
            x     = ctrl[vte_pkg::CTRL_THREE] ? sat(real'(a)) : sat(-real'(b + c));
            y     = sat(real'(c - b) / $sqrt(3.0));
            exp_q = {int'(x), int'(y), sat(x * co + y * s), sat(y * co - x * s)};
        end
        host_u.start(fwd, 1'b0, ctrl, 12'(a), 12'(b), 12'(c), ang);
        n = 0;
        chk_bits({11'h000, busy}, 12'h001);
        while (done !== 1'b1 && n < 60)
        begin
            if (poke && n == 5)
                host_u.start(1'b1, 1'b1, ctrl, 12'h000, 12'h000, 12'h000, ~ang);
            else
                @(negedge core_clk);
            n++;
        end
        chk_bits(12'(n), fwd ? 12'h028 : 12'h025);
        chk_val(fwd ? stator_voltage.a : stator_current.a, exp_q[0], fwd ? 8 : 1);
        chk_val(fwd ? stator_voltage.b : stator_current.b, exp_q[1], fwd ? 8 : 1);
        chk_val(fwd ? phase_voltage_out.p2 : rotor_current.a, exp_q[2], 10);
        chk_val(fwd ? phase_voltage_out.p3 : rotor_current.b, exp_q[3], 10);
        if (fwd)
            chk_val(phase_voltage_out.p1, exp_q[0], 8);
        chk_bits(system_status, ctrl[vte_pkg::CTRL_IRQ_EN] ? 12'h802 : 12'h000);
        host_u.read_status();
        chk_bits(system_status, 12'h000);
        chk_bits({11'h000, done}, 12'h000);
        if (poke)
        begin
            extra = 0;
            repeat (45)
            begin
                @(negedge core_clk);
                if (done !== 1'b0)
                    extra++;
            end
            chk_bits(12'(extra), 12'h000);
        end
    endtask : run

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        int i;
        int seed_ret;
        failures     = 0;
        total_checks = 0;
        resetn       = 1'b0;
        seed_ret     = $urandom(32'he4c99440);
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        chk_bits(system_status, 12'h000);
        chk_bits({10'h000, busy, done}, 12'h000);
        for (i = 0; i < 8; i++)
            run(1'b0, (i[0] ? 12'h400 : 12'h000) | (i[1] ? 12'h040 : 12'h000), rnd(), rnd(), rnd(),
                (i < 6) ? angs[i] : 12'($urandom), 1'b0);
        for (i = 0; i < 8; i++)
            run(1'b1, 12'h400 | (i[0] ? 12'h040 : 12'h000), rnd(), rnd(), 0,
                (i < 6) ? angs[i] : 12'($urandom), 1'b0);
        run(1'b0, 12'h040, 0, -2048, -2048, 12'h000, 1'b0);
        run(1'b0, 12'h000, 0, 2047, -2048, 12'h200, 1'b0);
        run(1'b1, 12'h440, 2047, 2047, 0, 12'h200, 1'b0);
        run(1'b0, 12'h040, rnd(), rnd(), rnd(), 12'h155, 1'b1);
        close_out();
    end

    initial
    begin
        #100000;
        failures++;
        close_out();
    end
endmodule : vector_transform_engine_tb_top
`default_nettype wire
